// ===== include/cplm_pkg.sv
package cplm_pkg;
  // =====================================================
  // register map (word aligned byte addresses)
  localparam logic [7:0] CPLM_CTRL_ADDR = 8'h00;
  localparam logic [7:0] CPLM_IRQ_ADDR = 8'h04;
  localparam logic [7:0] CPLM_STATUS_ADDR = 8'h08;
  // =====================================================
  // control register fields
  localparam int CPLM_CTL_SLEEP_REQUEST_BIT_POS = 0;
  localparam int CPLM_CTL_WAKE_EN_POS = 1;
  localparam int CPLM_CTL_STOPWAIT_POS = 2;
  localparam int CPLM_CTL_LISTEN_POS = 3;
  localparam int CPLM_CTL_MODULE_ON_POS = 4;
  localparam int CPLM_CTL_SLEEP_ACK_BIT_POS = 5;
  // =====================================================
  // wake interrupt register fields
  localparam int CPLM_IRQ_EN_POS = 0;
  localparam int CPLM_IRQ_FLAG_POS = 1;
  // =====================================================
  // reset values
  localparam logic [31:0] CPLM_CTRL_RESET = 32'h0000_0010;
  // =====================================================
  // timing
  localparam int CPLM_SYNC_DELAY_CYC = 3;
  localparam int CPLM_RECESSIVE_BITS = 11;
  localparam int CPLM_BUSOFF_SEQS = 128;
  localparam int CPLM_RESTART_CYC = 4;
  // =====================================================
  // mode states, gray coded along the usual path
  typedef enum logic [2:0] {
    CPLM_ST_NORMAL = 3'b000,
    CPLM_ST_SYNC = 3'b001,
    CPLM_ST_DRAIN = 3'b011,
    CPLM_ST_SLEEP = 3'b010,
    CPLM_ST_RESYNC = 3'b110,
    CPLM_ST_PDOWN = 3'b111,
    CPLM_ST_RESTART = 3'b101,
    CPLM_ST_OFF = 3'b100
  } cplm_state_t;
endpackage

// ===== rtl/cplm_mode_ctrl.sv
// What this block does
// - listen-only: frames received, but transmit pin only ever driven recessive
// - listen-only: no frame transmission is ever started
// - listen-only: dominant bits the MAC sends loop back internally to its monitor
// - module enable at 0 stops every internal clock
// - sleep stops internal clocks except those for register access
// - power-down stops all clocks; no register access
// - wake interrupt only with sleep active, wake enable and wake irq enable
// - with CPU running, sleep and module enable at 0 are the only reduced-power modes
// - wait instruction with stop-in-wait set forces power-down
// - leaving power-down restarts internal controllers then returns to normal
// - wait with stop-in-wait clear keeps normal or sleep and interrupts
// - CPU stop mode forces power-down regardless of sleep and stop-in-wait bits
// - sleep request: sync delay, finish transmit or reception, else sleep at once
// - sleep acknowledge set once sleep is entered
// - bus-off count paused in sleep with pin recessive, resumed after
// - in sleep rx full flag clearable, no move into foreground buffer
// - in sleep tx buffers accessible, empty flags clearable, no abort
// - wake enable clear masks receive input recessive; sampled at sleep entry
// - sleep left only on bus activity with wake enable, request cleared, or a power-down request
// - clearing sleep request ignored until sleep is active
// - after wake, wait 11 recessive bits before joining the bus
// - entering power-down aborts transfers and forces transmit pin recessive
//
// Implementation choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module cplm_mode_ctrl
  import cplm_pkg::*;
#(
  parameter int SYNC_CYC = cplm_pkg::CPLM_SYNC_DELAY_CYC,
  parameter int RESTART_CYC = cplm_pkg::CPLM_RESTART_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  input wire logic i_wb_we,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_cpu_stop,
  input wire logic i_cpu_wait,
  input wire logic i_mac_tx,
  input wire logic i_mac_tx_start_req,
  input wire logic i_mac_transmitting,
  input wire logic i_mac_receiving,
  input wire logic i_mac_bit_tick,
  input wire logic i_bus_off,
  input wire logic i_all_tx_empty,
  input wire logic i_bus_rx_pin,
  output logic o_bus_tx_pin,
  output logic o_mac_rx,
  output logic o_tx_start_grant,
  output logic o_core_clk_en,
  output logic o_reg_clk_en,
  output logic o_busoff_count_en,
  output logic o_rx_move_en,
  output logic o_abort_en,
  output logic o_mac_abort,
  output logic o_mac_online,
  output logic o_wake_irq
);
  import cplm_pkg::*;

  // =====================================================
  // state
  cplm_state_t state_reg, state_next;
  logic [7:0] cnt_reg, cnt_next;
  logic sleep_rq_reg, sleep_rq_next;
  logic wake_en_reg, wake_en_next;
  logic stop_wait_reg, stop_wait_next;
  logic listen_reg, listen_next;
  logic module_on_reg, module_on_next;
  logic on_locked_reg, on_locked_next;
  logic wake_latched_reg, wake_latched_next;
  logic irq_en_reg, irq_en_next;
  logic irq_flag_reg, irq_flag_next;
  logic [31:0] rdat_reg, rdat_next;
  logic ack_reg, ack_next;
  logic tx_reg, tx_next;
  logic mac_rx_reg, mac_rx_next;
  logic grant_reg, grant_next;
  logic core_en_reg, core_en_next;
  logic reg_en_reg, reg_en_next;
  logic bo_en_reg, bo_en_next;
  logic rxmv_reg, rxmv_next;
  logic abort_en_reg, abort_en_next;
  logic mabort_reg, mabort_next;
  logic online_reg, online_next;

  logic wr, rd, sleep_act, pdown_req, bus_act;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  // =====================================================
  // register bus and mode machine
  always_comb begin
    wr = i_wb_cyc && i_wb_stb && i_wb_we && !ack_reg && i_wb_sel[0];
    rd = i_wb_cyc && i_wb_stb && !ack_reg;
    sleep_act = sleep_rq_reg && (state_reg == CPLM_ST_SLEEP);
    pdown_req = i_cpu_stop || (i_cpu_wait && stop_wait_reg);
    // masked receive input cannot count as activity while wake is disabled
    bus_act = wake_latched_reg && !i_bus_rx_pin;
    state_next = state_reg;
    cnt_next = cnt_reg;
    sleep_rq_next = sleep_rq_reg;
    wake_en_next = wake_en_reg;
    stop_wait_next = stop_wait_reg;
    listen_next = listen_reg;
    module_on_next = module_on_reg;
    on_locked_next = on_locked_reg;
    wake_latched_next = wake_latched_reg;
    irq_en_next = irq_en_reg;
    irq_flag_next = irq_flag_reg;
    ack_next = rd;
    rdat_next = 32'h0000_0000;
    if (rd && !wr) begin
      if (hit(i_wb_adr, CPLM_CTRL_ADDR)) begin
        rdat_next[CPLM_CTL_SLEEP_REQUEST_BIT_POS] = sleep_rq_reg;
        rdat_next[CPLM_CTL_WAKE_EN_POS] = wake_en_reg;
        rdat_next[CPLM_CTL_STOPWAIT_POS] = stop_wait_reg;
        rdat_next[CPLM_CTL_LISTEN_POS] = listen_reg;
        rdat_next[CPLM_CTL_MODULE_ON_POS] = module_on_reg;
        rdat_next[CPLM_CTL_SLEEP_ACK_BIT_POS] = sleep_act;
      end else if (hit(i_wb_adr, CPLM_IRQ_ADDR)) begin
        rdat_next[CPLM_IRQ_EN_POS] = irq_en_reg;
        rdat_next[CPLM_IRQ_FLAG_POS] = irq_flag_reg;
      end else if (hit(i_wb_adr, CPLM_STATUS_ADDR)) begin
        rdat_next[2:0] = state_reg;
      end
    end
    if (wr && hit(i_wb_adr, CPLM_CTRL_ADDR)) begin
      // clearing the request only counts once sleep is active
      if (i_wb_dat[CPLM_CTL_SLEEP_REQUEST_BIT_POS] || sleep_act) begin
        sleep_rq_next = i_wb_dat[CPLM_CTL_SLEEP_REQUEST_BIT_POS];
      end
      wake_en_next = i_wb_dat[CPLM_CTL_WAKE_EN_POS];
      stop_wait_next = i_wb_dat[CPLM_CTL_STOPWAIT_POS];
      listen_next = i_wb_dat[CPLM_CTL_LISTEN_POS];
      // enable is write-once to guard against accidental disable
      if (!on_locked_reg) begin
        module_on_next = i_wb_dat[CPLM_CTL_MODULE_ON_POS];
        on_locked_next = 1'b1;
      end
    end
    if (wr && hit(i_wb_adr, CPLM_IRQ_ADDR)) begin
      irq_en_next = i_wb_dat[CPLM_IRQ_EN_POS];
      if (i_wb_dat[CPLM_IRQ_FLAG_POS]) begin
        irq_flag_next = 1'b0;
      end
    end
    case (state_reg)
      CPLM_ST_NORMAL: begin
        cnt_next = 8'h00;
        if (sleep_rq_reg) begin
          state_next = CPLM_ST_SYNC;
        end
      end
      CPLM_ST_SYNC: begin
        cnt_next = cnt_reg + 8'h01;
        if (cnt_reg >= 8'(SYNC_CYC - 1)) begin
          state_next = CPLM_ST_DRAIN;
        end
      end
      CPLM_ST_DRAIN: begin
        // the check against pending transmit is why software must wait for ack
        if (i_all_tx_empty && !i_mac_transmitting && !i_mac_receiving) begin
          state_next = CPLM_ST_SLEEP;
          wake_latched_next = wake_en_reg;
        end
      end
      CPLM_ST_SLEEP: begin
        cnt_next = 8'h00;
        if (bus_act || !sleep_rq_reg) begin
          state_next = CPLM_ST_RESYNC;
          if (bus_act) begin
            sleep_rq_next = 1'b0;
          end
        end
      end
      CPLM_ST_RESYNC: begin
        if (i_mac_bit_tick) begin
          cnt_next = i_bus_rx_pin ? cnt_reg + 8'h01 : 8'h00;
        end
        if (cnt_reg >= 8'(CPLM_RECESSIVE_BITS)) begin
          state_next = CPLM_ST_NORMAL;
        end
      end
      CPLM_ST_PDOWN: begin
        cnt_next = 8'h00;
        if (!pdown_req) begin
          state_next = CPLM_ST_RESTART;
        end
      end
      CPLM_ST_RESTART: begin
        cnt_next = cnt_reg + 8'h01;
        if (cnt_reg >= 8'(RESTART_CYC - 1)) begin
          state_next = CPLM_ST_NORMAL;
        end
      end
      CPLM_ST_OFF: begin
        if (module_on_reg) begin
          state_next = CPLM_ST_NORMAL;
        end
      end
      default: begin
        state_next = CPLM_ST_NORMAL;
      end
    endcase
    // wake flag: set wins over a simultaneous clear
    if (state_reg == CPLM_ST_SLEEP && sleep_act && bus_act && irq_en_reg) begin
      irq_flag_next = 1'b1;
    end
    if (pdown_req && module_on_reg) begin
      state_next = CPLM_ST_PDOWN;
    end
    if (!module_on_reg) begin
      state_next = CPLM_ST_OFF;
    end
  end

  // =====================================================
  // pin and enable outputs, all registered
  always_comb begin
    online_next = (state_next == CPLM_ST_NORMAL) || (state_next == CPLM_ST_SYNC)
      || (state_next == CPLM_ST_DRAIN);
    core_en_next = online_next || (state_next == CPLM_ST_RESYNC)
      || (state_next == CPLM_ST_RESTART);
    reg_en_next = (state_next != CPLM_ST_PDOWN) && (state_next != CPLM_ST_OFF);
    bo_en_next = i_bus_off && core_en_next;
    rxmv_next = online_next;
    abort_en_next = online_next;
    mabort_next = (state_next == CPLM_ST_PDOWN) || (state_next == CPLM_ST_OFF);
    // listen-only: drive recessive, loop dominant into the monitor
    tx_next = (listen_reg || !online_next) ? 1'b1 : i_mac_tx;
    if (state_next == CPLM_ST_SLEEP && !wake_latched_next) begin
      mac_rx_next = 1'b1;
    end else begin
      mac_rx_next = i_bus_rx_pin & (listen_reg ? i_mac_tx : 1'b1);
    end
    grant_next = i_mac_tx_start_req && !listen_reg && online_next
      && (state_next != CPLM_ST_DRAIN || i_mac_transmitting);
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      state_reg <= CPLM_ST_NORMAL;
      cnt_reg <= 8'h00;
      sleep_rq_reg <= CPLM_CTRL_RESET[CPLM_CTL_SLEEP_REQUEST_BIT_POS];
      wake_en_reg <= CPLM_CTRL_RESET[CPLM_CTL_WAKE_EN_POS];
      stop_wait_reg <= CPLM_CTRL_RESET[CPLM_CTL_STOPWAIT_POS];
      listen_reg <= CPLM_CTRL_RESET[CPLM_CTL_LISTEN_POS];
      module_on_reg <= CPLM_CTRL_RESET[CPLM_CTL_MODULE_ON_POS];
      on_locked_reg <= 1'b0;
      wake_latched_reg <= 1'b0;
      irq_en_reg <= 1'b0;
      irq_flag_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
      ack_reg <= 1'b0;
      tx_reg <= 1'b1;
      mac_rx_reg <= 1'b1;
      grant_reg <= 1'b0;
      core_en_reg <= 1'b1;
      reg_en_reg <= 1'b1;
      bo_en_reg <= 1'b0;
      rxmv_reg <= 1'b1;
      abort_en_reg <= 1'b1;
      mabort_reg <= 1'b0;
      online_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      sleep_rq_reg <= sleep_rq_next;
      wake_en_reg <= wake_en_next;
      stop_wait_reg <= stop_wait_next;
      listen_reg <= listen_next;
      module_on_reg <= module_on_next;
      on_locked_reg <= on_locked_next;
      wake_latched_reg <= wake_latched_next;
      irq_en_reg <= irq_en_next;
      irq_flag_reg <= irq_flag_next;
      rdat_reg <= rdat_next;
      ack_reg <= ack_next;
      tx_reg <= tx_next;
      mac_rx_reg <= mac_rx_next;
      grant_reg <= grant_next;
      core_en_reg <= core_en_next;
      reg_en_reg <= reg_en_next;
      bo_en_reg <= bo_en_next;
      rxmv_reg <= rxmv_next;
      abort_en_reg <= abort_en_next;
      mabort_reg <= mabort_next;
      online_reg <= online_next;
    end
  end

  assign o_wb_dat = rdat_reg;
  assign o_wb_ack = ack_reg;
  assign o_bus_tx_pin = tx_reg;
  assign o_mac_rx = mac_rx_reg;
  assign o_tx_start_grant = grant_reg;
  assign o_core_clk_en = core_en_reg;
  assign o_reg_clk_en = reg_en_reg;
  assign o_busoff_count_en = bo_en_reg;
  assign o_rx_move_en = rxmv_reg;
  assign o_abort_en = abort_en_reg;
  assign o_mac_abort = mabort_reg;
  assign o_mac_online = online_reg;
  assign o_wake_irq = irq_flag_reg;

  // =====================================================
  // checks
  property p_listen_tx;
    @(posedge i_ref_clk) disable iff (i_reset) listen_reg |=> o_bus_tx_pin;
  endproperty
  a_listen_tx: assert property (p_listen_tx) else $error("tx dominant in listen");
  property p_listen_grant;
    @(posedge i_ref_clk) disable iff (i_reset) $past(listen_reg) |-> !o_tx_start_grant;
  endproperty
  a_listen_grant: assert property (p_listen_grant) else $error("start in listen");
  property p_off_clk;
    @(posedge i_ref_clk) disable iff (i_reset) !module_on_reg |=> !o_core_clk_en;
  endproperty
  a_off_clk: assert property (p_off_clk) else $error("clocks run while off");
  property p_sleep_regs;
    @(posedge i_ref_clk) disable iff (i_reset)
      state_reg == CPLM_ST_SLEEP |-> o_reg_clk_en && !o_core_clk_en;
  endproperty
  a_sleep_regs: assert property (p_sleep_regs) else $error("sleep clocks wrong");
  property p_pdown;
    @(posedge i_ref_clk) disable iff (i_reset)
      state_reg == CPLM_ST_PDOWN |-> !o_reg_clk_en && o_bus_tx_pin && o_mac_abort;
  endproperty
  a_pdown: assert property (p_pdown) else $error("power-down outputs wrong");
  property p_stop;
    @(posedge i_ref_clk) disable iff (i_reset)
      i_cpu_stop && module_on_reg |=> state_reg == CPLM_ST_PDOWN;
  endproperty
  a_stop: assert property (p_stop) else $error("stop missed power-down");
  property p_irq;
    @(posedge i_ref_clk) disable iff (i_reset)
      $rose(irq_flag_reg) |-> $past(sleep_act) && $past(irq_en_reg) && $past(wake_latched_reg);
  endproperty
  a_irq: assert property (p_irq) else $error("wake irq without cause");
  property p_resync;
    @(posedge i_ref_clk) disable iff (i_reset)
      state_reg == CPLM_ST_RESYNC && state_next == CPLM_ST_NORMAL
      |-> cnt_reg >= 8'(CPLM_RECESSIVE_BITS);
  endproperty
  a_resync: assert property (p_resync) else $error("joined before 11 bits");
endmodule
`default_nettype wire

// ===== testbench/cplm_bus_node.sv
`timescale 1ns/1ns
`default_nettype none
// =====================================================
// far side: other nodes on a wired-and bus, idle recessive
module cplm_bus_node #(
  parameter int BIT_CYC = 4
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_tx_pin,
  input wire logic i_other_dominant,
  output logic o_rx_pin,
  output logic o_bit_tick
);
  logic [7:0] cnt_reg;
  // dominant from any node wins; released bus floats back to recessive
  assign o_rx_pin = i_tx_pin & ~i_other_dominant;
  always_ff @(posedge i_ref_clk) begin
    if (i_reset || cnt_reg == 8'(BIT_CYC - 1)) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
  assign o_bit_tick = (cnt_reg == 8'(BIT_CYC - 1));
endmodule
`default_nettype wire

// ===== testbench/can_power_listen_mode_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %s exp=%0h got=%0h", nm, e, g); end end
module can_power_listen_mode_ctrl_tb;
  import cplm_pkg::*;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, stop = 0, wt = 0;
  logic mtx = 1, sreq = 0, mtxg = 0, mrxg = 0, boff = 0, empty = 1, odom = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, q;
  logic [31:0] rdat;
  logic ack, txp, rxp, tick, mrx, grant, cen, ren, bcen, mv, aen, mab, onl, irq;
  int error_cnt = 0, comparisons = 0, cycles = 0, seed = 32'hFA49, n;
  logic [3:0] sel = 4'hF;
  localparam int SYNC_CYC_WAIT = CPLM_SYNC_DELAY_CYC + 6;
  localparam int RESTART_P = CPLM_RESTART_CYC;
  always #4 clk = ~clk;
  cplm_bus_node u_node (.i_ref_clk(clk), .i_reset(rst), .i_tx_pin(txp),
    .i_other_dominant(odom), .o_rx_pin(rxp), .o_bit_tick(tick));
  cplm_mode_ctrl u_dut (.i_ref_clk(clk), .i_reset(rst), .i_wb_adr(adr), .i_wb_dat(wdat),
    .i_wb_sel(sel), .i_wb_we(we), .i_wb_cyc(cyc), .i_wb_stb(stb), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_cpu_stop(stop), .i_cpu_wait(wt), .i_mac_tx(mtx),
    .i_mac_tx_start_req(sreq), .i_mac_transmitting(mtxg), .i_mac_receiving(mrxg),
    .i_mac_bit_tick(tick), .i_bus_off(boff), .i_all_tx_empty(empty), .i_bus_rx_pin(rxp),
    .o_bus_tx_pin(txp), .o_mac_rx(mrx), .o_tx_start_grant(grant), .o_core_clk_en(cen),
    .o_reg_clk_en(ren), .o_busoff_count_en(bcen), .o_rx_move_en(mv), .o_abort_en(aen),
    .o_mac_abort(mab), .o_mac_online(onl), .o_wake_irq(irq));
  // =====================================================
  // expectations
  function automatic logic [31:0] ctl(logic rq, logic wk, logic sw, logic ls);
    ctl = 32'h0;
    ctl[CPLM_CTL_SLEEP_REQUEST_BIT_POS] = rq;
    ctl[CPLM_CTL_WAKE_EN_POS] = wk;
    ctl[CPLM_CTL_STOPWAIT_POS] = sw;
    ctl[CPLM_CTL_LISTEN_POS] = ls;
    ctl[CPLM_CTL_MODULE_ON_POS] = 1'b1;
  endfunction
  // =====================================================
  // wishbone master; called right after a rising edge
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    adr <= a;
    we <= w;
    wdat <= d;
    cyc <= 1'b1;
    stb <= 1'b1;
    // no own limit here: only the hang guard ends a wait
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask
  task automatic cyc_n(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic test_done;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // hang guard: whole run needs a few hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      test_done;
    end
  end
  // =====================================================
  // main sequence
  initial begin
    cyc_n(20);
    rst <= 1'b0;
    cyc_n(1);
    wb(CPLM_CTRL_ADDR, 0, 0);
    `CHK("ctrl reset", CPLM_CTRL_RESET, q)
    wb(8'h3C, 0, 0);
    `CHK("unmapped", 32'h0, q)
    // a write without the low byte lane must not land nor lock the enable
    sel <= 4'hE;
    wb(CPLM_CTRL_ADDR, 1, ctl(0, 0, 0, 1));
    sel <= 4'hF;
    wb(CPLM_CTRL_ADDR, 0, 0);
    `CHK("sel refused", CPLM_CTRL_RESET, q)
    // random bus traffic, normal then listen-only
    for (int i = 0; i < 32; i++) begin
      if (i == 16) wb(CPLM_CTRL_ADDR, 1, ctl(0, 0, 0, 1));
      mtx <= 1'($random(seed));
      odom <= 1'($random(seed));
      sreq <= 1'($random(seed));
      cyc_n(4);
      `CHK("tx pin", (i < 16) ? mtx : 1'b1, txp)
      `CHK("grant", sreq & (i < 16), grant)
      `CHK("mac rx", mtx & ~odom, mrx)
    end
    wb(CPLM_CTRL_ADDR, 1, ctl(0, 0, 0, 0));
    // sleep request while a frame goes out and another comes in
    odom <= 1'b0;
    sreq <= 1'b0;
    mtx <= 1'b0;
    boff <= 1'b1;
    mtxg <= 1'b1;
    mrxg <= 1'b1;
    empty <= 1'b0;
    wb(CPLM_IRQ_ADDR, 1, 32'h1);
    wb(CPLM_CTRL_ADDR, 1, ctl(1, 1, 0, 0));
    cyc_n(SYNC_CYC_WAIT);
    wb(CPLM_STATUS_ADDR, 0, 0);
    `CHK("drain state", CPLM_ST_DRAIN, q[2:0])
    wb(CPLM_CTRL_ADDR, 1, ctl(0, 1, 0, 0));
    wb(CPLM_CTRL_ADDR, 0, 0);
    `CHK("rq kept", ctl(1, 1, 0, 0), q)
    empty <= 1'b1;
    mtxg <= 1'b0;
    cyc_n(4);
    wb(CPLM_STATUS_ADDR, 0, 0);
    `CHK("rx drain", CPLM_ST_DRAIN, q[2:0])
    mrxg <= 1'b0;
    // software treats it as asleep only once ack reads set
    n = 0;
    do begin
      wb(CPLM_CTRL_ADDR, 0, 0);
      n++;
    end while (q[CPLM_CTL_SLEEP_ACK_BIT_POS] !== 1'b1 && n < 20);
    `CHK("ack set", 1'b1, q[CPLM_CTL_SLEEP_ACK_BIT_POS])
    `CHK("core clk", 1'b0, cen)
    `CHK("reg clk", 1'b1, ren)
    `CHK("busoff cnt", 1'b0, bcen)
    `CHK("tx pin", 1'b1, txp)
    `CHK("rx move", 1'b0, mv)
    `CHK("abort en", 1'b0, aen)
    // wake from bus activity
    mtx <= 1'b1;
    odom <= 1'b1;
    cyc_n(8);
    odom <= 1'b0;
    cyc_n(2);
    `CHK("wake irq", 1'b1, irq)
    n = 0;
    while (onl !== 1'b1 && n < 200) begin
      cyc_n(1);
      n++;
    end
    `CHK("resync wait", 1'b1, n >= 40 && n < 200)
    `CHK("busoff resume", 1'b1, bcen)
    wb(CPLM_IRQ_ADDR, 1, 32'h3);
    cyc_n(2);
    `CHK("irq clear", 1'b0, irq)
    // sleep without wake enable: activity is masked
    wb(CPLM_CTRL_ADDR, 1, ctl(1, 0, 0, 0));
    cyc_n(8);
    odom <= 1'b1;
    cyc_n(8);
    `CHK("rx masked", 1'b1, mrx)
    odom <= 1'b0;
    wb(CPLM_STATUS_ADDR, 0, 0);
    `CHK("still asleep", CPLM_ST_SLEEP, q[2:0])
    `CHK("no irq", 1'b0, irq)
    wb(CPLM_CTRL_ADDR, 1, ctl(0, 0, 0, 0));
    n = 0;
    do begin
      wb(CPLM_STATUS_ADDR, 0, 0);
      n++;
    end while (q[2:0] !== CPLM_ST_NORMAL && n < 60);
    `CHK("cpu wake", CPLM_ST_NORMAL, q[2:0])
    // wait with and without stop-in-wait, then stop
    wt <= 1'b1;
    cyc_n(4);
    wb(CPLM_STATUS_ADDR, 0, 0);
    `CHK("wait normal", CPLM_ST_NORMAL, q[2:0])
    `CHK("run core clk", 1'b1, cen)
    wt <= 1'b0;
    wb(CPLM_CTRL_ADDR, 1, ctl(0, 0, 1, 0));
    mtx <= 1'b0;
    wt <= 1'b1;
    cyc_n(3);
    `CHK("pd core", 1'b0, cen)
    `CHK("pd reg", 1'b0, ren)
    `CHK("pd tx", 1'b1, txp)
    `CHK("pd abort", 1'b1, mab)
    wt <= 1'b0;
    mtx <= 1'b1;
    cyc_n(RESTART_P + 3);
    wb(CPLM_STATUS_ADDR, 0, 0);
    `CHK("restart", CPLM_ST_NORMAL, q[2:0])
    wb(CPLM_CTRL_ADDR, 1, ctl(0, 0, 0, 0));
    stop <= 1'b1;
    cyc_n(3);
    `CHK("stop core", 1'b0, cen)
    stop <= 1'b0;
    cyc_n(RESTART_P + 3);
    // second reset: the enable is write-once, so only a fresh reset lets it fall
    rst <= 1'b1;
    cyc_n(2);
    rst <= 1'b0;
    cyc_n(1);
    wb(CPLM_CTRL_ADDR, 0, 0);
    `CHK("ctrl re-reset", CPLM_CTRL_RESET, q)
    wb(CPLM_CTRL_ADDR, 1, 32'h0);
    cyc_n(3);
    `CHK("off core", 1'b0, cen)
    wb(CPLM_CTRL_ADDR, 1, ctl(0, 0, 0, 0));
    cyc_n(3);
    `CHK("off stays", 1'b0, cen)
    wb(CPLM_CTRL_ADDR, 0, 0);
    `CHK("enable locked", 32'h0, q)
    test_done;
  end
endmodule
`default_nettype wire
